/* File: dv/pfr_bank_sva.sv */
// assertion checker for the filter and eeprom status bank
`timescale 1ns/10ps
module pfr_bank_chk (
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic EE_VALID_IN,
  input wire logic EE_PROG_DONE_IN,
  input wire logic [7:0] EE_CRC_IN,
  input wire logic [7:0] EE_CNT_IN,
  input wire logic EE_FETCH_OUT,
  input wire logic LOAD_BUSY_OUT,
  input wire logic [2:0] C3_CODE_OUT,
  input wire logic [5:0] C3_PF_OUT,
  input wire logic [1:0] CLSD_SEL_OUT,
  input wire logic [10:0] CLSD_US_OUT,
  input wire logic [1:0] VCO_SEL_OUT,
  input wire logic [13:0] VCO_US_OUT,
  input wire logic [7:0] CRC_OUT,
  input wire logic [7:0] PROG_COUNT_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // ==========================================
  // sequences and properties
  sequence s_fetch;
    EE_FETCH_OUT && EE_VALID_IN ##1 !EE_FETCH_OUT;
  endsequence
  property p_load;
    s_fetch |=> !LOAD_BUSY_OUT && CRC_OUT == $past(EE_CRC_IN, 2);
  endproperty
  property p_r3_rsvd;
    REG_RD_IN && !LOAD_BUSY_OUT && REG_ADDR_IN == 8'h26
      |=> !REG_RDATA_OUT[7];
  endproperty
  property p_c3;
    C3_PF_OUT == 6'(C3_CODE_OUT) * 6'h05;
  endproperty
  property p_clsd;
    CLSD_SEL_OUT == 2'h3 |-> CLSD_US_OUT == 11'h7D0;
  endproperty
  property p_vco;
    VCO_SEL_OUT == 2'h3 |-> VCO_US_OUT == 14'h2710;
  endproperty
  property p_crc_ro;
    REG_WR_IN && !LOAD_BUSY_OUT |=> $stable(CRC_OUT);
  endproperty
  property p_inc;
    EE_PROG_DONE_IN && EE_CNT_IN != 8'hFF
      |=> PROG_COUNT_OUT == $past(EE_CNT_IN) + 8'h01;
  endproperty
  property p_sat;
    EE_PROG_DONE_IN && EE_CNT_IN == 8'hFF |=> PROG_COUNT_OUT == 8'hFF;
  endproperty
  a_load: assert property (p_load) else $error("load wrong");
  a_r3_rsvd: assert property (p_r3_rsvd) else $error("r3 bit7");
  a_c3: assert property (p_c3) else $error("c3 pf wrong");
  a_clsd: assert property (p_clsd) else $error("clsd us");
  a_vco: assert property (p_vco) else $error("vco us");
  a_crc_ro: assert property (p_crc_ro) else $error("crc moved");
  a_inc: assert property (p_inc) else $error("count inc");
  a_sat: assert property (p_sat) else $error("count sat");
endmodule : pfr_bank_chk
bind pfr_bank pfr_bank_chk i_chk (.*);

/* File: dv/pfr_bank_test.sv */
// self-checking bench for the filter and eeprom status bank
`timescale 1ns/10ps
module pfr_bank_test;
  import pfr_pkg::*;
  logic clk, rst_b, wr, rd, req, valid, done, fetch, busy, ack;
  logic [7:0] addr, wdata, rdata, crc, cnt, crc_q, cnt_q;
  logic [6:0] r3, r3_q;
  logic [2:0] c3, c3_q;
  logic [3:0] cal, lag;
  logic [11:0] ohm;
  logic [5:0] pf;
  logic [1:0] cs, vs;
  logic [10:0] cus;
  logic [13:0] vus;
  int failures, checked, cyc;
  pfr_bank i_dut (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .REG_ACK_OUT(ack), .EE_LOAD_REQ_IN(req),
    .EE_VALID_IN(valid), .EE_PROG_DONE_IN(done), .EE_R3_IN(r3),
    .EE_C3_IN(c3), .EE_CAL_IN(cal), .EE_CRC_IN(crc), .EE_CNT_IN(cnt),
    .EE_FETCH_OUT(fetch), .LOAD_BUSY_OUT(busy), .R3_CODE_OUT(r3_q),
    .R3_OHMS_OUT(ohm), .C3_CODE_OUT(c3_q), .C3_PF_OUT(pf),
    .CLSD_SEL_OUT(cs), .CLSD_US_OUT(cus), .VCO_SEL_OUT(vs),
    .VCO_US_OUT(vus), .CRC_OUT(crc_q), .PROG_COUNT_OUT(cnt_q));
  pfr_ee_model i_ee (.clk_in(clk), .rst_b_in(rst_b), .fetch_in(fetch),
    .lag_in(lag), .valid_out(valid));
  // ==========================================
  // tasks
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic stop_test();
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic wrr(logic [7:0] a, logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : wrr
  task automatic rdc(logic [7:0] a, logic [7:0] e);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk("ack", ack, 1'b1);
    chk("rdata", rdata, e);
    @(negedge clk);
  endtask : rdc
  task automatic prog(logic [7:0] c);
    cnt = c;
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    @(negedge clk);
  endtask : prog
  task automatic idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 50) begin
      @(negedge clk);
      k++;
    end
    if (k == 50) failures++;
  endtask : idle
  // ==========================================
  // clock and timeout
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      failures++;
      stop_test();
    end
  end
  // ==========================================
  // tests
  initial begin
    {rst_b, wr, rd, req, done, addr, wdata} = '0;
    lag = 4'h2;
    r3 = 7'h09;
    c3 = 3'h3;
    cal = 4'hE;
    crc = 8'hA5;
    cnt = 8'h05;
    repeat (16) @(negedge clk);
    chk("cal", {cs, vs}, 4'h9);
    chk("r3", r3_q, 7'h00);
    chk("crc", crc_q, 8'h00);
    rst_b = 1'b1;
    @(negedge clk);
    idle();
    chk("ohm", ohm, 12'h470);
    chk("pf", pf, 6'h0F);
    chk("cus", cus, 11'h7D0);
    chk("vus", vus, 14'h0FA0);
    chk("crc", crc_q, 8'hA5);
    chk("cnt", cnt_q, 8'h05);
    chk("fetch", fetch, 1'b0);
    for (int i = 0; i < R3_TAB_N; i++) begin
      wrr(8'h26, {1'b1, R3_TAB_CODE[i]});
      chk("ohm", ohm, R3_TAB_OHM[i]);
      chk("r3", r3_q, R3_TAB_CODE[i]);
      rdc(8'h26, {1'b0, R3_TAB_CODE[i]});
    end
    wrr(8'h27, 8'hFF);
    chk("pf", pf, 6'h23);
    chk("c3", c3_q, 3'h7);
    rdc(8'h27, 8'h07);
    for (int i = 0; i < 4; i++) begin
      wrr(8'h2A, {4'hF, 2'(i), 2'(3 - i)});
      chk("cus", cus, CLSD_TAB_US[i]);
      chk("vus", vus, VCO_TAB_US[3 - i]);
      rdc(8'h2A, {4'h0, 2'(i), 2'(3 - i)});
    end
    wrr(8'h2F, 8'h00);
    wrr(8'h30, 8'h00);
    rdc(8'h2F, 8'hA5);
    rdc(8'h30, 8'h05);
    rdc(8'h31, 8'h00);
    prog(8'hFE);
    chk("cnt", cnt_q, 8'hFF);
    prog(8'hFF);
    chk("cnt", cnt_q, 8'hFF);
    prog(8'h07);
    chk("cnt", cnt_q, 8'h08);
    lag = 4'h6;
    r3 = 7'h11;
    crc = 8'h3C;
    cnt = 8'h20;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    chk("fetch", fetch, 1'b1);
    addr = 8'h26;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk("ack", ack, 1'b0);
    wrr(8'h26, 8'h03);
    idle();
    chk("ohm", ohm, 12'h790);
    chk("crc", crc_q, 8'h3C);
    chk("cnt", cnt_q, 8'h20);
    stop_test();
  end
endmodule : pfr_bank_test

/* File: dv/pfr_ee_model.sv */
// eeprom store model answering the bank's fetch requests
`timescale 1ns/10ps
module pfr_ee_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // handshake
  input wire logic fetch_in,
  input wire logic [3:0] lag_in,
  output logic valid_out
);
  logic [3:0] cnt_reg;
  // ==========================================
  // image ready after lag
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg <= 4'h0;
      valid_out <= 1'b0;
    end else begin
      cnt_reg <= fetch_in ? cnt_reg + 4'h1 : 4'h0;
      valid_out <= fetch_in && (cnt_reg >= lag_in);
    end
  end
endmodule : pfr_ee_model

/* File: hdl/pfr_bank.sv */
// loop filter, calibration wait and eeprom status register bank
`timescale 1ns/10ps
module pfr_bank (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_B_IN,
  // register port from the serial interface engine
  input wire logic [pfr_pkg::ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [pfr_pkg::DATA_W-1:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [pfr_pkg::DATA_W-1:0] REG_RDATA_OUT,
  output logic REG_ACK_OUT,
  // eeprom side
  input wire logic EE_LOAD_REQ_IN,
  input wire logic EE_VALID_IN,
  input wire logic EE_PROG_DONE_IN,
  input wire logic [pfr_pkg::R3_W-1:0] EE_R3_IN,
  input wire logic [pfr_pkg::C3_W-1:0] EE_C3_IN,
  input wire logic [pfr_pkg::CAL_W-1:0] EE_CAL_IN,
  input wire logic [pfr_pkg::DATA_W-1:0] EE_CRC_IN,
  input wire logic [pfr_pkg::DATA_W-1:0] EE_CNT_IN,
  output logic EE_FETCH_OUT,
  output logic LOAD_BUSY_OUT,
  // settings to the pll
  output logic [pfr_pkg::R3_W-1:0] R3_CODE_OUT,
  output logic [pfr_pkg::OHM_W-1:0] R3_OHMS_OUT,
  output logic [pfr_pkg::C3_W-1:0] C3_CODE_OUT,
  output logic [pfr_pkg::PF_W-1:0] C3_PF_OUT,
  output logic [pfr_pkg::SEL_W-1:0] CLSD_SEL_OUT,
  output logic [pfr_pkg::CLSD_US_W-1:0] CLSD_US_OUT,
  output logic [pfr_pkg::SEL_W-1:0] VCO_SEL_OUT,
  output logic [pfr_pkg::VCO_US_W-1:0] VCO_US_OUT,
  // status
  output logic [pfr_pkg::DATA_W-1:0] CRC_OUT,
  output logic [pfr_pkg::DATA_W-1:0] PROG_COUNT_OUT
);
  import pfr_pkg::*;

  pfr_load_if ld ();

  logic [R3_W-1:0] r3_reg, r3_next;
  logic [C3_W-1:0] c3_reg, c3_next;
  logic [SEL_W-1:0] clsd_reg, clsd_next;
  logic [SEL_W-1:0] vco_reg, vco_next;
  logic [DATA_W-1:0] crc_reg, crc_next;
  logic [OHM_W-1:0] ohm_reg, ohm_next;
  logic [PF_W-1:0] pf_reg, pf_next;
  logic [CLSD_US_W-1:0] clsd_us_reg, clsd_us_next;
  logic [VCO_US_W-1:0] vco_us_reg, vco_us_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic [DATA_W-1:0] count;
  logic wr_ok;
  logic rd_ok;

  // ==========================================================
  // submodules
  pfr_load_seq u_seq (
    .clk_in(REF_CLK_IN),
    .rst_b_in(RST_B_IN),
    .ee_valid_in(EE_VALID_IN),
    .ld(ld.seq)
  );

  pfr_prog_count u_count (
    .clk_in(REF_CLK_IN),
    .rst_b_in(RST_B_IN),
    .load_in(ld.capture),
    .cycle_done_in(EE_PROG_DONE_IN),
    .stored_in(EE_CNT_IN),
    .count_out(count)
  );

  assign ld.start = EE_LOAD_REQ_IN;

  // ==========================================================
  // register access and load
  assign wr_ok = REG_WR_IN && !ld.busy;
  assign rd_ok = REG_RD_IN && !ld.busy;

  always_comb begin
    r3_next = r3_reg;
    c3_next = c3_reg;
    clsd_next = clsd_reg;
    vco_next = vco_reg;
    crc_next = crc_reg;
    rdata_next = rdata_reg;
    ack_next = 1'b0;
    if (ld.capture) begin
      r3_next = EE_R3_IN;
      c3_next = EE_C3_IN;
      clsd_next = EE_CAL_IN[CLSD_LSB +: SEL_W];
      vco_next = EE_CAL_IN[VCO_LSB +: SEL_W];
      crc_next = EE_CRC_IN;
    end else if (wr_ok) begin
      unique case (REG_ADDR_IN)
        OFS_RESISTOR3: r3_next = REG_WDATA_IN[R3_W-1:0];
        OFS_CAPACITOR3: c3_next = REG_WDATA_IN[C3_W-1:0];
        OFS_CAL_WAIT: begin
          clsd_next = REG_WDATA_IN[CLSD_LSB +: SEL_W];
          vco_next = REG_WDATA_IN[VCO_LSB +: SEL_W];
        end
        default: begin
          r3_next = r3_reg;
        end
      endcase
    end
    if (rd_ok) begin
      ack_next = 1'b1;
      unique case (REG_ADDR_IN)
        OFS_RESISTOR3: rdata_next = DATA_W'(r3_reg);
        OFS_CAPACITOR3: rdata_next = DATA_W'(c3_reg);
        OFS_CAL_WAIT: rdata_next = DATA_W'({clsd_reg, vco_reg});
        OFS_STORED_CRC: rdata_next = crc_reg;
        OFS_PROG_COUNT: rdata_next = count;
        default: rdata_next = '0;
      endcase
    end
    ohm_next = pfr_r3_ohms(r3_next);
    pf_next = PF_W'(C3_PF_STEP * {3'h0, c3_next});
    clsd_us_next = CLSD_TAB_US[clsd_next];
    vco_us_next = VCO_TAB_US[vco_next];
  end

  always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      r3_reg <= R3_RST;
      c3_reg <= C3_RST;
      clsd_reg <= CLSD_RST;
      vco_reg <= VCO_RST;
      crc_reg <= CRC_RST;
      ohm_reg <= R3_TAB_OHM[0];
      pf_reg <= '0;
      clsd_us_reg <= CLSD_TAB_US[CLSD_RST];
      vco_us_reg <= VCO_TAB_US[VCO_RST];
      rdata_reg <= '0;
      ack_reg <= 1'b0;
    end else begin
      r3_reg <= r3_next;
      c3_reg <= c3_next;
      clsd_reg <= clsd_next;
      vco_reg <= vco_next;
      crc_reg <= crc_next;
      ohm_reg <= ohm_next;
      pf_reg <= pf_next;
      clsd_us_reg <= clsd_us_next;
      vco_us_reg <= vco_us_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
    end
  end

  // ==========================================================
  // outputs
  assign REG_RDATA_OUT = rdata_reg;
  assign REG_ACK_OUT = ack_reg;
  assign EE_FETCH_OUT = ld.fetch;
  assign LOAD_BUSY_OUT = ld.busy;
  assign R3_CODE_OUT = r3_reg;
  assign R3_OHMS_OUT = ohm_reg;
  assign C3_CODE_OUT = c3_reg;
  assign C3_PF_OUT = pf_reg;
  assign CLSD_SEL_OUT = clsd_reg;
  assign CLSD_US_OUT = clsd_us_reg;
  assign VCO_SEL_OUT = vco_reg;
  assign VCO_US_OUT = vco_us_reg;
  assign CRC_OUT = crc_reg;
  assign PROG_COUNT_OUT = count;

endmodule : pfr_bank

/* File: hdl/pfr_load_seq.sv */
// eeprom to register load sequencer, runs once after reset and per commit
`timescale 1ns/10ps
module pfr_load_seq (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // eeprom data ready
  input wire logic ee_valid_in,
  // bank side
  pfr_load_if.seq ld
);
  import pfr_pkg::*;

  pfr_load_state_t state_reg, state_next;
  logic boot_reg, boot_next;
  logic fetch_reg, fetch_next;
  logic capture_reg, capture_next;
  logic busy_reg, busy_next;

  // ==========================================================
  // next state
  always_comb begin
    state_next = state_reg;
    boot_next = boot_reg;
    unique case (state_reg)
      PFR_IDLE: begin
        if (boot_reg || ld.start) begin
          state_next = PFR_FETCH;
          boot_next = 1'b0;
        end
      end
      PFR_FETCH: begin
        if (ee_valid_in) begin
          state_next = PFR_LOAD;
        end
      end
      PFR_LOAD: begin
        state_next = PFR_IDLE;
      end
      default: begin
        state_next = PFR_IDLE;
      end
    endcase
    fetch_next = (state_next == PFR_FETCH);
    capture_next = (state_next == PFR_LOAD);
    busy_next = (state_next != PFR_IDLE);
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= PFR_IDLE;
      boot_reg <= 1'b1;
      fetch_reg <= 1'b0;
      capture_reg <= 1'b0;
      busy_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      boot_reg <= boot_next;
      fetch_reg <= fetch_next;
      capture_reg <= capture_next;
      busy_reg <= busy_next;
    end
  end

  assign ld.fetch = fetch_reg;
  assign ld.capture = capture_reg;
  assign ld.busy = busy_reg;

endmodule : pfr_load_seq

/* File: hdl/pfr_prog_count.sv */
// saturating eeprom erase/program cycle counter
`timescale 1ns/10ps
module pfr_prog_count (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // events
  input wire logic load_in,
  input wire logic cycle_done_in,
  input wire logic [7:0] stored_in,
  // count
  output logic [7:0] count_out
);
  import pfr_pkg::*;

  logic [7:0] count_reg, count_next;

  // ==========================================================
  // next value
  always_comb begin
    count_next = count_reg;
    if (cycle_done_in) begin
      count_next = pfr_sat_inc(stored_in);
    end else if (load_in) begin
      count_next = stored_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_reg <= CNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count_out = count_reg;

endmodule : pfr_prog_count

/* File: include/pfr_load_if.sv */
// handshake between the register bank and its eeprom load sequencer
`timescale 1ns/10ps
interface pfr_load_if;
  logic start;
  logic fetch;
  logic capture;
  logic busy;
  modport bank (output start, input fetch, input capture, input busy);
  modport seq (input start, output fetch, output capture, output busy);
endinterface : pfr_load_if

/* File: include/pfr_pkg.sv */
// constants, tables and types for the pll filter and eeprom status bank
// What this block does
// - 7-bit resistor3 code, reset zero, top reserved
// - listed resistor3 codes map to ohm values
// - 3-bit capacitor3 code, five picofarads per step
// - closed-loop wait select bits 3:2, reset 2
// - vco wait select bits 1:0, reset 1
// - read-only stored crc byte from eeprom
// - read-only erase/program count, hardware increments
// - count reloads after reset, commit, program
// - program count saturates at 255
// - eeprom copied to registers at reset, commit
package pfr_pkg;

  // ==========================================================
  // widths and register offsets
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned R3_W = 7;
  localparam int unsigned C3_W = 3;
  localparam int unsigned SEL_W = 2;
  localparam int unsigned CAL_W = 4;
  localparam int unsigned OHM_W = 12;
  localparam int unsigned PF_W = 6;
  localparam int unsigned CLSD_US_W = 11;
  localparam int unsigned VCO_US_W = 14;
  localparam logic [7:0] OFS_RESISTOR3 = 8'h26;
  localparam logic [7:0] OFS_CAPACITOR3 = 8'h27;
  localparam logic [7:0] OFS_CAL_WAIT = 8'h2A;
  localparam logic [7:0] OFS_STORED_CRC = 8'h2F;
  localparam logic [7:0] OFS_PROG_COUNT = 8'h30;

  // ==========================================================
  // field positions and reset values
  localparam int unsigned CLSD_LSB = 2;
  localparam int unsigned VCO_LSB = 0;
  localparam logic [6:0] R3_RST = 7'h00;
  localparam logic [2:0] C3_RST = 3'h0;
  localparam logic [1:0] CLSD_RST = 2'h2;
  localparam logic [1:0] VCO_RST = 2'h1;
  localparam logic [7:0] CRC_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [5:0] C3_PF_STEP = 6'h05;

  // ==========================================================
  // lookup tables
  localparam int unsigned R3_TAB_N = 7;
  // codes 0,3,8,9,12,17,20
  localparam logic [6:0] R3_TAB_CODE [R3_TAB_N] = '{
    7'h00, 7'h03, 7'h08, 7'h09, 7'h0C, 7'h11, 7'h14};
  // ohms 18,205,854,1136,1535,1936,2335
  localparam logic [11:0] R3_TAB_OHM [R3_TAB_N] = '{
    12'h012, 12'h0CD, 12'h356, 12'h470, 12'h5FF, 12'h790, 12'h91F};
  // microseconds 150,300,500,2000
  localparam logic [10:0] CLSD_TAB_US [4] = '{
    11'h096, 11'h12C, 11'h1F4, 11'h7D0};
  // microseconds 20,400,4000,10000
  localparam logic [13:0] VCO_TAB_US [4] = '{
    14'h0014, 14'h0190, 14'h0FA0, 14'h2710};

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    PFR_IDLE  = 2'b00,
    PFR_FETCH = 2'b01,
    PFR_LOAD  = 2'b11
  } pfr_load_state_t;

  // ==========================================================
  // functions
  // listed code lookup
  function automatic logic [11:0] pfr_r3_ohms(input logic [6:0] code);
    logic [11:0] ohm;
    ohm = 12'h000;
    for (int i = 0; i < R3_TAB_N; i++) begin
      if (R3_TAB_CODE[i] == code) begin
        ohm = R3_TAB_OHM[i];
      end
    end
    return ohm;
  endfunction : pfr_r3_ohms

  function automatic logic [7:0] pfr_sat_inc(input logic [7:0] val);
    return (val == CNT_MAX) ? CNT_MAX : 8'(val + CNT_ONE);
  endfunction : pfr_sat_inc

endpackage : pfr_pkg
